// ===== eleef_map.vh
// Register map, field positions, reset values and timing counts of the link entry and error flag block.
`ifndef ELEEF_MAP_VH
`define ELEEF_MAP_VH

// Register byte offsets on the APB (8-bit address).
`define ELEEF_OFF_CTRL 8'h00
`define ELEEF_OFF_STATUS 8'h04
`define ELEEF_OFF_TS_MIN 8'h08
`define ELEEF_OFF_TS_MAX 8'h0C
`define ELEEF_OFF_TS_TOL 8'h10
`define ELEEF_OFF_T1 8'h14

// Control register fields.
`define ELEEF_CTRL_FMODE_LSB 0
`define ELEEF_CTRL_FMODE_MSB 1
`define ELEEF_CTRL_RESET 2'h0

// Status register fields.
`define ELEEF_ST_STATE_LSB 0
`define ELEEF_ST_STATE_MSB 2
`define ELEEF_ST_LINK 3
`define ELEEF_ST_OVT 4
`define ELEEF_ST_PDOWN 5
`define ELEEF_ST_REVPOL 6
`define ELEEF_ST_ERR 7
`define ELEEF_ST_ABORT 8

// Function modes.
`define ELEEF_FM_ABZ_UVW 2'h0
`define ELEEF_FM_ABZ_SER 2'h1
`define ELEEF_FM_LOOPBACK 2'h2
`define ELEEF_FM_BUS 2'h3

// Phase timing bounds in microseconds, reset values.
`define ELEEF_TS_MIN_RESET 16'h0028
`define ELEEF_TS_MAX_RESET 16'h003C
`define ELEEF_TS_TOL_RESET 16'h000A

// Time base: clock rate in MHz and the tick period in microseconds.
`define ELEEF_CLK_MHZ 10
`define ELEEF_TICK_US 1
`define ELEEF_TICK_CYCLES (`ELEEF_CLK_MHZ * `ELEEF_TICK_US)
`define ELEEF_DIV_W 4
`define ELEEF_TIME_W 16

`endif

// ===== eleef_phase_timer.v
// Saturating phase duration counter advanced by a time base enable.
module eleef_phase_timer #(
   parameter W = 16
) (
   // Clock and reset.
   input wire pclk,
   input wire presetn,
   // Control.
   input wire clr,
   input wire tick,
   // Elapsed time in ticks.
   output wire [W-1:0] count
);

   reg [W-1:0] count_ff;
   reg [W-1:0] nxt_count;

   // Clear wins over a tick so a new phase always starts at zero.
   always @* begin
      nxt_count = count_ff;
      if (clr) begin
         nxt_count = {W{1'b0}};
      end else if (tick && (count_ff != {W{1'b1}})) begin
         nxt_count = count_ff + {{(W-1){1'b0}}, 1'b1};
      end
   end

   // Saturation keeps an overlong phase from wrapping into a legal window.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_ff <= {W{1'b0}};
      end else begin
         count_ff <= nxt_count;
      end
   end

   assign count = count_ff;

endmodule // eleef_phase_timer

// ===== eleef_top.v
// Link entry sequence detector, bypass routing and error flag logic with an APB register file.
//
// Function
// - Overtemperature tristates every differential output stage.
// - Power-down holds all differential output stages tristated.
// - Error output low on any fault condition except reverse polarity.
// - Error input level forwarded to error output.
// - Reverse polarity: supply off, all outputs tristated.
// - Bypass links nine or six sensor lines.
// - Entry sequence accepted only with permit high.
// - First phase duration measured and stored.
// - Second phase complementary within reference tolerance.
// - Third phase both low within tolerance.
// - Release after third phase enters bypass.
// - Any violation aborts; restart from phase one.
// - Permit low leaves the bypass state.
// - Power-down also leaves the bypass state.
// - Bypass drives sensor mode pin half supply.
//
// The implementer's own choices: the APB slave port and the register offsets.
`include "eleef_map.vh"

module eleef_top (
   // Clock and reset.
   input wire pclk,
   input wire presetn,
   // APB slave.
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // Protection events.
   input wire overtemp_event,
   input wire power_down_event,
   input wire reverse_polarity_event,
   // Control pins.
   input wire output_enable_pin,
   input wire error_in_n,
   input wire link_permit,
   // Line driver data and sensor inputs.
   input wire [5:0] drive_data,
   input wire [5:0] sensor_in_pos,
   input wire [5:0] sensor_in_neg,
   // Sensed levels of line pair one.
   input wire line_pos_1_in,
   input wire line_neg_1_in,
   // Line outputs, enables low while driving.
   output wire [5:0] line_pos_n,
   output wire [5:0] line_neg_n,
   output wire [5:0] line_oe_n,
   // Open-drain error output.
   output wire error_out_n,
   output wire error_out_oe_n,
   // Sensor mode control and supply switches.
   output wire sensor_mode_ctrl,
   output wire switched_supply,
   output wire switched_ground,
   output wire internal_supply_en,
   output wire link_active
);

   // Sequence states.
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_PH1 = 3'h1;
   localparam [2:0] ST_PH2 = 3'h2;
   localparam [2:0] ST_PH3 = 3'h3;
   localparam [2:0] ST_LINK = 3'h4;
   localparam [2:0] ST_ABORT = 3'h5;

   // The divider end count is cut to the divider width on purpose.
   localparam [31:0] TICK_LAST_W = (`ELEEF_TICK_CYCLES) - 1;
   localparam [`ELEEF_DIV_W-1:0] TICK_LAST = TICK_LAST_W[`ELEEF_DIV_W-1:0];

   // Register file state.
   reg [1:0] fmode_ff;
   reg [15:0] ts_min_ff;
   reg [15:0] ts_max_ff;
   reg [15:0] ts_tol_ff;
   reg [15:0] t1_ff;
   reg abort_flag_ff;
   reg [31:0] prdata_ff;
   reg pready_ff;
   reg pslverr_ff;

   // Sequence and output state.
   reg [2:0] state_ff;
   reg [2:0] nxt_state;
   reg [15:0] nxt_t1;
   reg timer_clr;
   reg seq_abort;
   reg [`ELEEF_DIV_W-1:0] div_ff;
   reg tick_ff;
   reg [5:0] line_pos_ff;
   reg [5:0] line_neg_ff;
   reg [5:0] line_oe_n_ff;
   reg error_out_oe_n_ff;
   reg sensor_mode_ff;
   reg supply_sw_ff;
   reg internal_supply_ff;
   reg link_ff;
   reg [5:0] nxt_pos;
   reg [5:0] nxt_neg;
   reg [5:0] nxt_oe_n;

   wire [15:0] phase_time;
   wire both_hi;
   wire both_lo;
   wire compl;
   wire [16:0] win_hi;
   wire [15:0] win_lo;
   wire fault_any;
   wire tristate_all;
   wire setup_ph;
   wire wr_en;
   wire addr_ok;

   // Pair one level decode.
   assign both_hi = line_pos_1_in & line_neg_1_in;
   assign both_lo = ~line_pos_1_in & ~line_neg_1_in;
   assign compl = line_pos_1_in ^ line_neg_1_in;

   // Acceptance window around the stored first phase.
   assign win_hi = {1'b0, t1_ff} + {1'b0, ts_tol_ff};
   assign win_lo = (t1_ff > ts_tol_ff) ? (t1_ff - ts_tol_ff) : 16'h0000;

   // Time base divider producing a one-cycle microsecond enable.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_ff <= {`ELEEF_DIV_W{1'b0}};
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= (div_ff == TICK_LAST);
         if (div_ff == TICK_LAST) begin
            div_ff <= {`ELEEF_DIV_W{1'b0}};
         end else begin
            div_ff <= div_ff + {{(`ELEEF_DIV_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // Phase duration counter, restarted at each phase boundary.
   eleef_phase_timer #(
      .W(`ELEEF_TIME_W)
   ) u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .clr(timer_clr),
      .tick(tick_ff),
      .count(phase_time)
   );

   // Entry sequence state machine; a bad level or time sends it to the abort state.
   always @* begin
      nxt_state = state_ff;
      nxt_t1 = t1_ff;
      timer_clr = 1'b0;
      seq_abort = 1'b0;
      if (!link_permit || power_down_event) begin
         nxt_state = ST_IDLE;
         timer_clr = 1'b1;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               timer_clr = 1'b1;
               if (both_hi) begin
                  nxt_state = ST_PH1;
               end
            end
            ST_PH1: begin
               if (both_hi) begin
                  if (phase_time >= ts_max_ff) begin
                     seq_abort = 1'b1;
                  end
               end else if (compl && (phase_time > ts_min_ff) && (phase_time < ts_max_ff)) begin
                  nxt_t1 = phase_time;
                  timer_clr = 1'b1;
                  nxt_state = ST_PH2;
               end else begin
                  seq_abort = 1'b1;
               end
            end
            ST_PH2: begin
               if (compl) begin
                  if ({1'b0, phase_time} >= win_hi) begin
                     seq_abort = 1'b1;
                  end
               end else if (both_lo && (phase_time > win_lo)) begin
                  timer_clr = 1'b1;
                  nxt_state = ST_PH3;
               end else begin
                  seq_abort = 1'b1;
               end
            end
            ST_PH3: begin
               if (both_lo) begin
                  if ({1'b0, phase_time} >= win_hi) begin
                     seq_abort = 1'b1;
                  end
               end else if (compl && (phase_time > win_lo)) begin
                  timer_clr = 1'b1;
                  nxt_state = ST_LINK;
               end else begin
                  seq_abort = 1'b1;
               end
            end
            ST_LINK: begin
               timer_clr = 1'b1;
            end
            ST_ABORT: begin
               // Waiting for the pins to leave the high level keeps a stale first phase from being timed.
               timer_clr = 1'b1;
               if (!both_hi) begin
                  nxt_state = ST_IDLE;
               end
            end
            default: begin
               nxt_state = ST_IDLE;
               timer_clr = 1'b1;
            end
         endcase
         if (seq_abort) begin
            nxt_state = ST_ABORT;
            timer_clr = 1'b1;
         end
      end
   end

   // Sequence state and stored reference duration.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ST_IDLE;
         t1_ff <= 16'h0000;
      end else begin
         state_ff <= nxt_state;
         t1_ff <= nxt_t1;
      end
   end

   // Fault decode for the error flag and the output stages.
   assign fault_any = overtemp_event | power_down_event | ~output_enable_pin | ~error_in_n;
   assign tristate_all = overtemp_event | power_down_event | reverse_polarity_event | ~output_enable_pin;

   // Line routing: bypass links sensor pins, otherwise the drivers carry the data.
   always @* begin : route
      integer i;
      i = 0;
      nxt_pos = drive_data;
      nxt_neg = ~drive_data;
      nxt_oe_n = 6'h00;
      if (fmode_ff == `ELEEF_FM_LOOPBACK) begin
         // Channels one and two are off in loopback outside the bypass state, so the pair can be pulled externally.
         nxt_oe_n[0] = 1'b1;
         nxt_oe_n[1] = 1'b1;
      end
      if ((state_ff != ST_IDLE) && (state_ff != ST_LINK)) begin
         // Pair one belongs to the calibration equipment while the sequence runs.
         nxt_oe_n[0] = 1'b1;
      end
      if (state_ff == ST_LINK) begin
         for (i = 0; i < 6; i = i + 1) begin
            if ((i < 3) || (fmode_ff == `ELEEF_FM_ABZ_UVW)) begin
               nxt_pos[i] = sensor_in_pos[i];
               nxt_oe_n[i] = 1'b0;
            end
            if (i < 3) begin
               nxt_neg[i] = sensor_in_neg[i];
            end
         end
      end
      if (tristate_all) begin
         nxt_oe_n = 6'h3F;
      end
   end

   // Registered pin drive; every output except the constant error_out_n comes from a flip-flop.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_pos_ff <= 6'h00;
         line_neg_ff <= 6'h00;
         line_oe_n_ff <= 6'h3F;
         error_out_oe_n_ff <= 1'b0;
         sensor_mode_ff <= 1'b0;
         supply_sw_ff <= 1'b0;
         internal_supply_ff <= 1'b0;
         link_ff <= 1'b0;
      end else begin
         line_pos_ff <= nxt_pos;
         line_neg_ff <= nxt_neg;
         line_oe_n_ff <= nxt_oe_n;
         // Reverse polarity releases the error pin even though a fault is present.
         error_out_oe_n_ff <= reverse_polarity_event | ~fault_any;
         sensor_mode_ff <= (nxt_state == ST_LINK) && !reverse_polarity_event;
         supply_sw_ff <= ~reverse_polarity_event;
         internal_supply_ff <= ~reverse_polarity_event;
         link_ff <= (nxt_state == ST_LINK);
      end
   end

   // APB decode; the answer is prepared in the setup cycle so the access phase never waits.
   assign setup_ph = psel & ~penable;
   assign wr_en = psel & penable & pready_ff & pwrite;
   assign addr_ok = (paddr == `ELEEF_OFF_CTRL) || (paddr == `ELEEF_OFF_STATUS) ||
                    (paddr == `ELEEF_OFF_TS_MIN) || (paddr == `ELEEF_OFF_TS_MAX) ||
                    (paddr == `ELEEF_OFF_TS_TOL) || (paddr == `ELEEF_OFF_T1);

   // Read mux, answer strobe and error for unmapped addresses.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h00000000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff <= setup_ph;
         pslverr_ff <= setup_ph & ~addr_ok;
         if (setup_ph && !pwrite) begin
            case (paddr)
               `ELEEF_OFF_CTRL: prdata_ff <= {30'h00000000, fmode_ff};
               `ELEEF_OFF_STATUS: prdata_ff <= {23'h000000, abort_flag_ff, ~error_out_oe_n_ff,
                                                ~internal_supply_ff, power_down_event, overtemp_event,
                                                link_ff, state_ff};
               `ELEEF_OFF_TS_MIN: prdata_ff <= {16'h0000, ts_min_ff};
               `ELEEF_OFF_TS_MAX: prdata_ff <= {16'h0000, ts_max_ff};
               `ELEEF_OFF_TS_TOL: prdata_ff <= {16'h0000, ts_tol_ff};
               `ELEEF_OFF_T1: prdata_ff <= {16'h0000, t1_ff};
               default: prdata_ff <= 32'h00000000;
            endcase
         end else if (setup_ph) begin
            prdata_ff <= 32'h00000000;
         end
      end
   end

   // Writable registers; a write lands at the edge where pready is sampled high.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fmode_ff <= `ELEEF_CTRL_RESET;
         ts_min_ff <= `ELEEF_TS_MIN_RESET;
         ts_max_ff <= `ELEEF_TS_MAX_RESET;
         ts_tol_ff <= `ELEEF_TS_TOL_RESET;
      end else if (wr_en) begin
         case (paddr)
            `ELEEF_OFF_CTRL: fmode_ff <= pwdata[`ELEEF_CTRL_FMODE_MSB:`ELEEF_CTRL_FMODE_LSB];
            `ELEEF_OFF_TS_MIN: ts_min_ff <= pwdata[15:0];
            `ELEEF_OFF_TS_MAX: ts_max_ff <= pwdata[15:0];
            `ELEEF_OFF_TS_TOL: ts_tol_ff <= pwdata[15:0];
            default: fmode_ff <= fmode_ff;
         endcase
      end
   end

   // Sticky abort flag; an abort in the clearing cycle wins over the clear.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         abort_flag_ff <= 1'b0;
      end else if (seq_abort) begin
         abort_flag_ff <= 1'b1;
      end else if (wr_en && (paddr == `ELEEF_OFF_STATUS) && pwdata[`ELEEF_ST_ABORT]) begin
         abort_flag_ff <= 1'b0;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign line_pos_n = line_pos_ff;
   assign line_neg_n = line_neg_ff;
   assign line_oe_n = line_oe_n_ff;
   // The open-drain pin only ever pulls low.
   assign error_out_n = 1'b0;
   assign error_out_oe_n = error_out_oe_n_ff;
   assign sensor_mode_ctrl = sensor_mode_ff;
   assign switched_supply = supply_sw_ff;
   assign switched_ground = supply_sw_ff;
   assign internal_supply_en = internal_supply_ff;
   assign link_active = link_ff;

endmodule // eleef_top

// ===== eleef_asserts.sv
// Port checker for the link entry and error flag block, with its bind.
module eleef_asserts (
   // Clock and reset.
   input wire pclk,
   input wire presetn,
   // Fault and control pins.
   input wire overtemp_event,
   input wire power_down_event,
   input wire reverse_polarity_event,
   input wire output_enable_pin,
   input wire error_in_n,
   input wire link_permit,
   // Sensor pins and line outputs.
   input wire [5:0] sensor_in_pos,
   input wire [5:0] sensor_in_neg,
   input wire [5:0] line_pos_n,
   input wire [5:0] line_neg_n,
   input wire [5:0] line_oe_n,
   // Status and supply outputs.
   input wire error_out_oe_n,
   input wire sensor_mode_ctrl,
   input wire switched_supply,
   input wire switched_ground,
   input wire internal_supply_en,
   input wire link_active
);
   // All checks run on the one clock and stand idle in reset.
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_ovt_tri;
      overtemp_event |=> &line_oe_n;
   endproperty
   a_ovt_tri: assert property (p_ovt_tri) else $error("line driven in overtemperature");
   property p_pd_tri;
      power_down_event |=> &line_oe_n;
   endproperty
   a_pd_tri: assert property (p_pd_tri) else $error("line driven in power down");
   property p_err_low;
      !reverse_polarity_event && (overtemp_event || power_down_event || !output_enable_pin) |=> !error_out_oe_n;
   endproperty
   a_err_low: assert property (p_err_low) else $error("error pin not pulled");
   // The forwarded level is compared with the input one cycle back, the registered latency.
   property p_err_fwd;
      !reverse_polarity_event && !overtemp_event && !power_down_event && output_enable_pin
         |=> error_out_oe_n == $past(error_in_n);
   endproperty
   a_err_fwd: assert property (p_err_fwd) else $error("error input not forwarded");
   property p_revpol;
      reverse_polarity_event |=> &line_oe_n && error_out_oe_n && !internal_supply_en && !switched_supply
         && !switched_ground;
   endproperty
   a_revpol: assert property (p_revpol) else $error("reverse polarity not isolated");
   property p_permit;
      !link_permit [*3] |-> !link_active;
   endproperty
   a_permit: assert property (p_permit) else $error("bypass without permit");
   property p_exit;
      $fell(link_permit) |-> ##[1:3] !link_active;
   endproperty
   a_exit: assert property (p_exit) else $error("bypass kept after permit low");
   property p_pd_exit;
      power_down_event |-> ##[1:3] !link_active;
   endproperty
   a_pd_exit: assert property (p_pd_exit) else $error("bypass kept in power down");
   property p_sel_mode;
      sensor_mode_ctrl == (link_active && !$past(reverse_polarity_event));
   endproperty
   a_sel_mode: assert property (p_sel_mode) else $error("sensor mode pin off bypass");
   property p_bypass;
      link_active && $past(link_active) |-> line_pos_n[2:0] == $past(sensor_in_pos[2:0])
         && line_neg_n[2:0] == $past(sensor_in_neg[2:0]);
   endproperty
   a_bypass: assert property (p_bypass) else $error("sensor lines not linked");

   c_link: cover property ($rose(link_active));
   c_err: cover property ($fell(error_out_oe_n));
   c_rev: cover property (reverse_polarity_event);
endmodule // eleef_asserts

bind eleef_top eleef_asserts eleef_asserts_inst (.pclk(pclk), .presetn(presetn),
   .overtemp_event(overtemp_event), .power_down_event(power_down_event),
   .reverse_polarity_event(reverse_polarity_event), .output_enable_pin(output_enable_pin),
   .error_in_n(error_in_n), .link_permit(link_permit), .sensor_in_pos(sensor_in_pos),
   .sensor_in_neg(sensor_in_neg), .line_pos_n(line_pos_n), .line_neg_n(line_neg_n), .line_oe_n(line_oe_n),
   .error_out_oe_n(error_out_oe_n), .sensor_mode_ctrl(sensor_mode_ctrl), .switched_supply(switched_supply),
   .switched_ground(switched_ground), .internal_supply_en(internal_supply_en), .link_active(link_active));

// ===== eleef_cal_model.sv
// Behavioural calibration equipment that drives line pair one through the entry phases.
module eleef_cal_model (
   // Clock.
   input wire pclk,
   // Levels of pair one as the device senses them.
   output logic pos_1,
   output logic neg_1
);
   timeunit 1ns;
   timeprecision 1ns;

   // Released pair: the positive pin is pulled high and the negative pin low.
   initial begin
      pos_1 = 1'b1;
      neg_1 = 1'b0;
   end

   // One attempt; times are microseconds of ten clocks, so wrong lengths come from the caller.
   task automatic run(input int t1, input int t2, input int t3);
      @(posedge pclk);
      pos_1 <= 1'b1;
      neg_1 <= 1'b1;
      repeat (t1 * 10) @(posedge pclk);
      pos_1 <= 1'b1;
      neg_1 <= 1'b0;
      repeat (t2 * 10) @(posedge pclk);
      pos_1 <= 1'b0;
      neg_1 <= 1'b0;
      repeat (t3 * 10) @(posedge pclk);
      pos_1 <= 1'b1;
      neg_1 <= 1'b0;
   endtask
endmodule // eleef_cal_model

// ===== eleef_top_tb_top.sv
// Self-checking bench for the link entry and error flag block.
`include "eleef_map.vh"

module eleef_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, pos_1, neg_1;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic overtemp_event, power_down_event, reverse_polarity_event, output_enable_pin, error_in_n, link_permit;
   logic [5:0] drive_data, sensor_in_pos, sensor_in_neg, line_pos_n, line_neg_n, line_oe_n;
   logic error_out_oe_n, sensor_mode_ctrl, switched_supply, switched_ground, internal_supply_en, link_active;
   int fails = 0;
   int n_checks = 0;
   // Rows: overtemp, power down, reverse, enable, error in; then expected pin release, tristate.
   logic [6:0] rows [7] = '{7'h0E, 7'h4D, 7'h2D, 7'h05, 7'h08, 7'h1F, 7'h1B};
   // Each attempt breaks one phase length in microseconds.
   int bad [3][3] = '{'{35, 50, 50}, '{50, 65, 50}, '{50, 50, 36}};

   eleef_top eleef_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .overtemp_event(overtemp_event), .power_down_event(power_down_event),
      .reverse_polarity_event(reverse_polarity_event), .output_enable_pin(output_enable_pin),
      .error_in_n(error_in_n), .link_permit(link_permit), .drive_data(drive_data),
      .sensor_in_pos(sensor_in_pos), .sensor_in_neg(sensor_in_neg), .line_pos_1_in(pos_1),
      .line_neg_1_in(neg_1), .line_pos_n(line_pos_n), .line_neg_n(line_neg_n), .line_oe_n(line_oe_n),
      .error_out_n(), .error_out_oe_n(error_out_oe_n), .sensor_mode_ctrl(sensor_mode_ctrl),
      .switched_supply(switched_supply), .switched_ground(switched_ground),
      .internal_supply_en(internal_supply_en), .link_active(link_active));

   eleef_cal_model eleef_cal_model_inst (.pclk(pclk), .pos_1(pos_1), .neg_1(neg_1));

   // Free running 10 MHz clock.
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; the idle cycle at the end keeps psel from being set twice in one step.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic s);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // The slave sets the pace; only the watchdog ends a wait that is never answered.
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      s = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rg(input logic [7:0] a, input logic [31:0] exp, input logic err);
      apb(1'b0, a, 32'h0, q, e);
      chk(q, exp);
      chk(e, err);
   endtask

   task automatic wait_link(input logic v);
      repeat (40) begin
         if (link_active === v) break;
         @(posedge pclk);
      end
      chk(link_active, v);
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Main sequence: reset, registers, fault rows, refused and broken attempts, every mode.
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {overtemp_event, power_down_event, reverse_polarity_event} = 3'h0;
      {output_enable_pin, error_in_n, link_permit} = 3'h7;
      presetn = 1'b0;
      drive_data = 6'h36;
      sensor_in_pos = 6'h15;
      sensor_in_neg = 6'h2A;
      repeat (16) @(posedge pclk);
      chk(line_oe_n, 6'h3F);
      chk({error_out_oe_n, link_active}, 2'h0);
      presetn <= 1'b1;
      rg(`ELEEF_OFF_CTRL, 32'h0, 1'b0);
      rg(`ELEEF_OFF_TS_MIN, `ELEEF_TS_MIN_RESET, 1'b0);
      rg(`ELEEF_OFF_TS_MAX, `ELEEF_TS_MAX_RESET, 1'b0);
      rg(`ELEEF_OFF_TS_TOL, `ELEEF_TS_TOL_RESET, 1'b0);
      rg(8'h40, 32'h0, 1'b1);
      foreach (rows[i]) begin
         {overtemp_event, power_down_event, reverse_polarity_event, output_enable_pin, error_in_n} <= rows[i][6:2];
         repeat (3) @(posedge pclk);
         chk(error_out_oe_n, rows[i][1]);
         chk(line_oe_n, {6{rows[i][0]}});
         chk({switched_supply, switched_ground, internal_supply_en}, {3{~rows[i][4]}});
         if (!rows[i][0]) chk(line_pos_n, drive_data);
      end
      {overtemp_event, power_down_event, reverse_polarity_event, output_enable_pin, error_in_n} <= 5'h03;
      link_permit <= 1'b0;
      eleef_cal_model_inst.run(50, 50, 50);
      repeat (30) @(posedge pclk);
      chk(link_active, 1'b0);
      link_permit <= 1'b1;
      foreach (bad[i]) begin
         eleef_cal_model_inst.run(bad[i][0], bad[i][1], bad[i][2]);
         repeat (30) @(posedge pclk);
         chk(link_active, 1'b0);
      end
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, `ELEEF_OFF_CTRL, m, q, e);
         eleef_cal_model_inst.run(50, 50, 50);
         wait_link(1'b1);
         chk(sensor_mode_ctrl, 1'b1);
         apb(1'b0, `ELEEF_OFF_T1, 32'h0, q, e);
         chk(q > 48 && q < 52, 1'b1);
         sensor_in_pos <= ~sensor_in_pos;
         sensor_in_neg <= ~sensor_in_neg;
         repeat (3) @(posedge pclk);
         chk(line_pos_n, m == 0 ? sensor_in_pos : {drive_data[5:3], sensor_in_pos[2:0]});
         chk(line_neg_n[2:0], sensor_in_neg[2:0]);
         if (m % 2 == 1) link_permit <= 1'b0;
         else power_down_event <= 1'b1;
         repeat (2) @(posedge pclk);
         {link_permit, power_down_event} <= 2'h2;
         wait_link(1'b0);
         chk(sensor_mode_ctrl, 1'b0);
         repeat (2) @(posedge pclk);
         chk(line_oe_n, m == 2 ? 6'h03 : 6'h00);
      end
      test_done();
   end

   // Guard against a hang: the whole run needs well under half of this span.
   initial begin
      #3000000;
      fails++;
      test_done();
   end
endmodule // eleef_top_tb_top
